// ===== tvd_regs.svh
`ifndef TVD_REGS_SVH
`define TVD_REGS_SVH

// Clock and access timing
`define TVD_CLK_NS     20
`define TVD_RD_CAP_NS  240
`define TVD_WS_NS      30
`define TVD_WL_NS      120
`define TVD_RD_CYC     (`TVD_RD_CAP_NS / `TVD_CLK_NS)
`define TVD_WS_CYC     ((`TVD_WS_NS + `TVD_CLK_NS - 1) / `TVD_CLK_NS)
`define TVD_WL_CYC     (`TVD_WL_NS / `TVD_CLK_NS)

// Character cell phases
`define TVD_PH_HALF    4'h8
`define TVD_PH_LAST    4'hF
`define TVD_PH_CHAR    4'h2

// Raster geometry
`define TVD_HTOT       7'h64
`define TVD_HS_BEG     7'h54
`define TVD_HS_END     7'h5C
`define TVD_COLS_N     7'h40
`define TVD_COLS_W     7'h50
`define TVD_ROWS_N     5'h10
`define TVD_ROWS_W     5'h18
`define TVD_LPR_N      5'h0C
`define TVD_LPR_W      5'h0A
`define TVD_VTOT_N     5'h14
`define TVD_VTOT_W     5'h1A
`define TVD_ROW_ADJ    4'hF
`define TVD_START_RST  14'h0000
`endif

// ===== tvd_pkg.sv
`default_nettype none
package tvd_pkg;
    // Operation register image, bit 7 down to bit 0
    typedef struct packed {
        logic       page;
        logic       map_dest;
        logic       map_enable;
        logic       map_source;
        logic       inverse;
        logic       wide;
        logic [1:0] map_sel;
    } tvd_opreg_t;

    // Processor side of a screen memory access
    typedef struct packed {
        logic        sel_n;
        logic        mem_read_n;
        logic        mem_write_n;
        logic [10:0] addr;
        logic [7:0]  data;
    } tvd_cpu_t;

    typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT, ACC_RUN, ACC_DONE} tvd_acc_t;
endpackage : tvd_pkg
`default_nettype wire

// ===== tvd_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "tvd_regs.svh"
module tvd_core (
    input  wire logic              CLK_IN,
    input  wire logic              RSTN_IN,
    input  wire logic              CE_IN,
    input  wire tvd_pkg::tvd_opreg_t OPREG_IN,
    input  wire logic              ALT_GLYPH_IN,
    input  wire logic              HIRES_IN,
    input  wire logic              DOT_SEL_IN,
    input  wire logic              START_WR_IN,
    input  wire logic [13:0]       START_ADDR_IN,
    input  wire tvd_pkg::tvd_cpu_t CPU_IN,
    input  wire logic [7:0]        GLYPH_DATA_IN,
    output var  logic              HSYNC_OUT,
    output var  logic              VSYNC_OUT,
    output var  logic              ACTIVE_AREA_OUT,
    output var  logic [13:0]       REFRESH_ADDR_OUT,
    output var  logic [4:0]        SCAN_ROW_OUT,
    output var  logic              ACCESS_PHASE_CLK_OUT,
    output var  logic              PIXEL_RATE_CLK_OUT,
    output var  logic              VRAM_STALL_N_OUT,
    output var  logic [7:0]        CPU_DATA_OUT,
    output var  logic              CPU_DATA_OE_OUT,
    output var  logic              RAM_OUTPUT_OFF_OUT,
    output var  logic              DELAYED_WRITE_STROBE_N_OUT,
    output var  logic              WRITE_BUFFER_EN_N_OUT,
    output var  logic [11:0]       GLYPH_ADDR_OUT,
    output var  logic              VIDEO_OUT
);
    import tvd_pkg::*;

    localparam int RD_CYC = `TVD_RD_CYC;
    localparam int WS_CYC = `TVD_WS_CYC;
    localparam int WE_CYC = `TVD_WS_CYC + `TVD_WL_CYC;

    ////////////////////////////////////////////////////////////////////
    // Cell phase and raster counters
    logic [3:0]  ph;
    logic [6:0]  col;
    logic [4:0]  scan;
    logic [4:0]  crow;
    logic [13:0] row_base;
    logic [13:0] start_q;
    logic        wide_q;
    logic        fmt_n;
    logic        acc_hi;
    logic [6:0]  cols;
    logic [4:0]  rows;
    logic [4:0]  lpr;
    logic [4:0]  vtot;
    logic        active;
    logic [13:0] refresh;

    // Format select seen by the timer is active low
    // format bit
    assign fmt_n  = ~OPREG_IN.wide;
    assign acc_hi = (ph < `TVD_PH_HALF);
    assign cols   = wide_q ? `TVD_COLS_W : `TVD_COLS_N;
    assign rows   = wide_q ? `TVD_ROWS_W : `TVD_ROWS_N;
    assign lpr    = wide_q ? `TVD_LPR_W : `TVD_LPR_N;
    assign vtot   = wide_q ? `TVD_VTOT_W : `TVD_VTOT_N;
    assign active = (col < cols) && (crow < rows);
    assign refresh = row_base + 14'(col);

    // Cell phase, sixteen clocks per character cell
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ph <= 4'h0;
        end else if (CE_IN) begin
            ph <= ph + 4'h1;
        end
    end

    // Display start written by software, taken at frame end
    // start address
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            start_q <= `TVD_START_RST;
        end else if (CE_IN && START_WR_IN) begin
            start_q <= START_ADDR_IN;
        end
    end

    // Column, scan line and character row walk
    // raster timing
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            col      <= 7'h00;
            scan     <= 5'h00;
            crow     <= 5'h00;
            row_base <= `TVD_START_RST;
            wide_q   <= 1'b0;
        end else if (CE_IN && ph == `TVD_PH_LAST) begin
            if (col != `TVD_HTOT - 7'h01) begin
                col <= col + 7'h01;
            end else begin
                col <= 7'h00;
                if (scan != lpr - 5'h01) begin
                    scan <= scan + 5'h01;
                end else begin
                    scan <= 5'h00;
                    if (crow != vtot - 5'h01) begin
                        crow     <= crow + 5'h01;
                        row_base <= row_base + 14'(cols);
                    end else begin
                        crow     <= 5'h00;
                        row_base <= start_q;
                        wide_q   <= ~fmt_n;
                    end
                end
            end
        end
    end

    // Timer outputs and buffered syncs
    // sync buffers
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            HSYNC_OUT        <= 1'b0;
            VSYNC_OUT        <= 1'b0;
            ACTIVE_AREA_OUT  <= 1'b0;
            REFRESH_ADDR_OUT <= 14'h0000;
            SCAN_ROW_OUT     <= 5'h00;
        end else if (CE_IN) begin
            HSYNC_OUT        <= (col >= `TVD_HS_BEG) && (col < `TVD_HS_END);
            VSYNC_OUT        <= (crow == rows + 5'h01);
            ACTIVE_AREA_OUT  <= active;
            REFRESH_ADDR_OUT <= refresh;
            SCAN_ROW_OUT     <= scan;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Screen memory and its address multiplexer
    logic [7:0]  vram [0:2047];
    logic [7:0]  ram_q;
    logic [7:0]  ram_cpu_q;
    logic [10:0] ref_va;
    logic [10:0] cpu_va;
    logic [10:0] mux_addr;
    logic        commit;

    assign ref_va = wide_q ? refresh[10:0] : {OPREG_IN.page, refresh[9:0]};
    assign cpu_va = wide_q ? CPU_IN.addr : {OPREG_IN.page, CPU_IN.addr[9:0]};
    assign mux_addr = acc_hi ? ref_va : cpu_va;

    always_ff @(posedge CLK_IN) begin
        if (CE_IN) begin
            ram_q <= vram[mux_addr];
            if (commit) begin
                vram[cpu_va] <= CPU_IN.data;
            end
        end
    end

    // Processor-phase RAM output, frozen while output is off
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ram_cpu_q <= 8'h00;
        end else if (CE_IN && ph >= 4'h9 && !RAM_OUTPUT_OFF_OUT) begin
            ram_cpu_q <= ram_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Processor access sequencer
    tvd_acc_t   acc;
    logic [3:0] cnt;
    logic       is_rd;
    logic       start;
    logic       seq_end;

    assign start   = (acc == ACC_WAIT) && (ph == `TVD_PH_HALF - 4'h1);
    assign seq_end = is_rd ? (cnt == 4'(RD_CYC)) : (cnt == 4'(WE_CYC));
    assign commit  = (acc == ACC_RUN) && !is_rd && (cnt == 4'(WE_CYC));

    // Access state and delay-line count
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            acc   <= ACC_IDLE;
            cnt   <= 4'h0;
            is_rd <= 1'b0;
        end else if (CE_IN) begin
            case (acc)
                ACC_IDLE: begin
                    if (!CPU_IN.sel_n) begin
                        acc <= ACC_WAIT;
                    end
                end
                ACC_WAIT: begin
                    if (CPU_IN.sel_n) begin
                        acc <= ACC_IDLE;
                    end else if (start) begin
                        acc   <= ACC_RUN;
                        cnt   <= 4'h1;
                        is_rd <= CPU_IN.mem_write_n;
                    end
                end
                ACC_RUN: begin
                    cnt <= cnt + 4'h1;
                    if (seq_end) begin
                        acc <= ACC_DONE;
                    end
                end
                ACC_DONE: begin
                    if (CPU_IN.sel_n) begin
                        acc <= ACC_IDLE;
                    end
                end
                default: begin
                    acc <= ACC_IDLE;
                end
            endcase
        end
    end

    // Stall from select until the phase edge capture
    // stall while refreshing
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            VRAM_STALL_N_OUT <= 1'b1;
        end else if (CE_IN) begin
            if (acc == ACC_IDLE && !CPU_IN.sel_n) begin
                VRAM_STALL_N_OUT <= 1'b0;
            end else if (start || CPU_IN.sel_n) begin
                VRAM_STALL_N_OUT <= 1'b1;
            end
        end
    end

    // Holding latch and its bus drive
    // read byte capture
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            CPU_DATA_OUT    <= 8'h00;
            CPU_DATA_OE_OUT <= 1'b0;
        end else if (CE_IN) begin
            if (acc == ACC_RUN && is_rd && cnt == 4'(RD_CYC)) begin
                CPU_DATA_OUT <= ram_cpu_q;
            end
            CPU_DATA_OE_OUT <= !CPU_IN.mem_read_n && !CPU_IN.sel_n;
        end
    end

    // RAM output off for a write, aligned to the processor phase
    // output disable
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RAM_OUTPUT_OFF_OUT <= 1'b0;
        end else if (CE_IN) begin
            RAM_OUTPUT_OFF_OUT <= !CPU_IN.sel_n && !CPU_IN.mem_write_n
                                  && (ph >= 4'h7) && (ph != `TVD_PH_LAST);
        end
    end

    // Delayed write strobe and data buffer enable
    // write strobe timing
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            DELAYED_WRITE_STROBE_N_OUT <= 1'b1;
            WRITE_BUFFER_EN_N_OUT      <= 1'b1;
        end else if (CE_IN && acc == ACC_RUN && !is_rd) begin
            if (cnt == 4'(WS_CYC)) begin
                DELAYED_WRITE_STROBE_N_OUT <= 1'b0;
                WRITE_BUFFER_EN_N_OUT      <= 1'b0;
            end else if (commit) begin
                DELAYED_WRITE_STROBE_N_OUT <= 1'b1;
                WRITE_BUFFER_EN_N_OUT      <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Character path: latch, glyph address, shifter, dots
    logic [7:0] chr_q;
    logic       inv_q;
    logic       act_q;
    logic       block;
    logic       text_glyph_n;
    logic       block_glyph_n;
    logic       serializer_fill_n;
    logic       a9;
    logic [3:0] row_adj;
    logic [1:0] pair;
    logic [7:0] pattern;
    logic [7:0] sh;
    logic       inv_sh;
    logic       dot;

    assign block         = chr_q[7] && !ALT_GLYPH_IN;
    assign block_glyph_n = ~block;
    assign text_glyph_n  = block;
    assign a9            = chr_q[6] && !(chr_q[7] && ALT_GLYPH_IN);
    assign row_adj = text_glyph_n ? scan[3:0] : scan[3:0] + `TVD_ROW_ADJ;
    assign serializer_fill_n = !(ph == `TVD_PH_LAST && act_q);

    // Block pattern: three bands of two cells
    always_comb begin
        if (scan < 5'h04) begin
            pair = chr_q[1:0];
        end else if (scan < 5'h08) begin
            pair = chr_q[3:2];
        end else begin
            pair = chr_q[5:4];
        end
        pattern = {{4{pair[0]}}, {4{pair[1]}}};
    end

    // Character latch with inverse gating of bit 7
    // inverse gating
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            chr_q <= 8'h00;
            inv_q <= 1'b0;
            act_q <= 1'b0;
        end else if (CE_IN && ph == `TVD_PH_CHAR) begin
            chr_q <= {ram_q[7] && !OPREG_IN.inverse, ram_q[6:0]};
            inv_q <= ram_q[7] && OPREG_IN.inverse;
            act_q <= active;
        end
    end

    // Glyph ROM address, refreshed every clock
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            GLYPH_ADDR_OUT <= 12'h000;
        end else if (CE_IN) begin
            GLYPH_ADDR_OUT <= {chr_q[7], chr_q[5], a9, chr_q[4:0], row_adj};
        end
    end

    // Parallel load at cell end, one shift per dot, zero fill
    // MSB first shifting
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sh     <= 8'h00;
            inv_sh <= 1'b0;
        end else if (CE_IN) begin
            if (!serializer_fill_n) begin
                sh     <= block_glyph_n ? GLYPH_DATA_IN : pattern;
                inv_sh <= inv_q;
            end else if (ph[0]) begin
                sh <= {sh[6:0], 1'b0};
                // A blank cell drops the inverse of the last glyph at its end
                if (ph == `TVD_PH_LAST) begin
                    inv_sh <= 1'b0;
                end
            end
        end
    end

    // Dot mixing with the chosen dot-rate clock phase
    // video mixing
    assign dot = DOT_SEL_IN ? ~ph[0] : ph[0];
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            VIDEO_OUT            <= 1'b0;
            PIXEL_RATE_CLK_OUT   <= 1'b0;
            ACCESS_PHASE_CLK_OUT <= 1'b1;
        end else if (CE_IN) begin
            VIDEO_OUT            <= (sh[7] ^ inv_sh ^ HIRES_IN) && dot;
            PIXEL_RATE_CLK_OUT   <= ~ph[0];
            ACCESS_PHASE_CLK_OUT <= (ph == `TVD_PH_LAST) || (ph < 4'h7);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN || !CE_IN);

    phase_mux_a: assert property (
        ACCESS_PHASE_CLK_OUT == acc_hi)
        else $error("access phase output out of step with mux");
    stall_assert_a: assert property (
        (acc == ACC_IDLE && !CPU_IN.sel_n) |=> !VRAM_STALL_N_OUT)
        else $error("stall not raised on select");
    stall_release_a: assert property (
        start |=> VRAM_STALL_N_OUT)
        else $error("stall not released at capture");
    read_hold_a: assert property (
        (start && CPU_IN.mem_write_n) |-> ##13 (CPU_DATA_OUT == $past(ram_cpu_q)))
        else $error("held byte not captured on time");
    data_drive_a: assert property (
        (CPU_IN.mem_read_n || CPU_IN.sel_n) |=> !CPU_DATA_OE_OUT)
        else $error("data driven outside read select");
    write_strobe_a: assert property (
        (start && !CPU_IN.mem_write_n) |=> DELAYED_WRITE_STROBE_N_OUT
        ##1 DELAYED_WRITE_STROBE_N_OUT
        ##1 (!DELAYED_WRITE_STROBE_N_OUT && !WRITE_BUFFER_EN_N_OUT) [*6]
        ##1 DELAYED_WRITE_STROBE_N_OUT)
        else $error("write strobe timing wrong");
    alt_bit_a: assert property (
        GLYPH_ADDR_OUT[9] == ($past(chr_q[6]) && !($past(chr_q[7]) && $past(ALT_GLYPH_IN))))
        else $error("glyph bit 9 gating wrong");
    row_adjust_a: assert property (
        $past(RSTN_IN) |-> GLYPH_ADDR_OUT[3:0] == ($past(block) ? $past(scan[3:0])
                                                   : $past(scan[3:0]) + 4'hF))
        else $error("glyph row adjust wrong");
    blank_zero_a: assert property (
        (ph == `TVD_PH_LAST && !act_q) |=> (sh == 8'h00 && !inv_sh))
        else $error("blank cell shifted data");
    start_load_a: assert property (
        START_WR_IN |=> (start_q == $past(START_ADDR_IN)))
        else $error("display start not stored");

    read_seen_c: cover property (start && CPU_IN.mem_write_n);
    write_seen_c: cover property (commit);
    block_seen_c: cover property (!serializer_fill_n && block);
    inverse_seen_c: cover property (!serializer_fill_n && inv_q);
endmodule : tvd_core
`default_nettype wire

// ===== tvd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tvd_host_model (
    input  wire logic              clk_in,
    input  wire logic              stall_n_in,
    input  wire logic              strobe_n_in,
    input  wire logic              phase_in,
    input  wire logic              oe_in,
    input  wire logic              off_in,
    input  wire logic [7:0]        data_in,
    output var  tvd_pkg::tvd_cpu_t cpu_out
);
    import tvd_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // Bus idle and not selected
    initial begin
        cpu_out = '{1'b1, 1'b1, 1'b1, 11'h7FF, 8'hFF};
    end
    ////////////////////////////////////////////////////////////////////////////
    // One access; returns stall length, strobe length and phase/oe/off flags
    task automatic access(input logic wr, input logic [10:0] a, input logic [7:0] d,
                          output logic [7:0] q, output int wait_n, output int low_n,
                          output logic [2:0] seen);
        int n;
        @(negedge clk_in);
        cpu_out = '{1'b0, wr, ~wr, a, d};
        n = 0;
        while (stall_n_in && n < 4) begin
            @(negedge clk_in);
            n++;
        end
        wait_n = 0;
        while (!stall_n_in && wait_n < 40) begin
            @(negedge clk_in);
            wait_n++;
        end
        seen = {phase_in, oe_in, off_in};
        low_n = 0;
        repeat (14) begin
            @(negedge clk_in);
            low_n += int'(strobe_n_in === 1'b0);
        end
        q = data_in;
        // Released lines show the inverse of the last value
        cpu_out = '{1'b1, 1'b1, 1'b1, ~a, ~d};
    endtask : access
endmodule : tvd_host_model
`default_nettype wire

// ===== tvd_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tvd_core_tb;
    import tvd_pkg::*;
    logic        clk, rstn, ce, alt, hires, dsel, start_wr;
    tvd_opreg_t  opreg;
    tvd_cpu_t    cpu;
    logic [7:0]  glyph, cdata;
    logic        hs, vs, act, phase, dot, stall_n, oe, off, strobe_n, buf_n, video;
    logic [13:0] raddr, saddr;
    logic [4:0]  srow;
    logic [11:0] gaddr;
    int          bad_count, total_checks;
    ////////////////////////////////////////////////////////////////////////////
    // Design and processor model
    tvd_core dut (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .OPREG_IN(opreg),
        .ALT_GLYPH_IN(alt), .HIRES_IN(hires), .DOT_SEL_IN(dsel), .START_WR_IN(start_wr),
        .START_ADDR_IN(saddr), .CPU_IN(cpu), .GLYPH_DATA_IN(glyph), .HSYNC_OUT(hs),
        .VSYNC_OUT(vs), .ACTIVE_AREA_OUT(act), .REFRESH_ADDR_OUT(raddr),
        .SCAN_ROW_OUT(srow), .ACCESS_PHASE_CLK_OUT(phase), .PIXEL_RATE_CLK_OUT(dot),
        .VRAM_STALL_N_OUT(stall_n), .CPU_DATA_OUT(cdata), .CPU_DATA_OE_OUT(oe),
        .RAM_OUTPUT_OFF_OUT(off), .DELAYED_WRITE_STROBE_N_OUT(strobe_n),
        .WRITE_BUFFER_EN_N_OUT(buf_n), .GLYPH_ADDR_OUT(gaddr), .VIDEO_OUT(video));
    tvd_host_model host (.clk_in(clk), .stall_n_in(stall_n), .strobe_n_in(strobe_n),
        .phase_in(phase), .oe_in(oe), .off_in(off), .data_in(cdata), .cpu_out(cpu));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare helpers
    task automatic chk_v(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_v
    task automatic chk_n(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_n
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic wait_hs_rise;
        int n;
        n = 0;
        while (hs !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        while (hs !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_hs_rise
    ////////////////////////////////////////////////////////////////////////////
    // Code gating, alternate set and row offset on the glyph address
    task automatic t_glyph;
        logic [7:0]  codes [4] = '{8'h41, 8'hC1, 8'hC1, 8'h81};
        logic [3:0]  inv_m = 4'b0100;
        logic [3:0]  alt_m = 4'b0110;
        logic [7:0]  q;
        logic [2:0]  seen;
        logic [15:0] e;
        logic        g7, a9, blk;
        int          w, l, n;
        for (int i = 0; i < 4; i++) begin
            opreg.inverse = inv_m[i];
            alt = alt_m[i];
            host.access(1'b1, 11'h005, codes[i], q, w, l, seen);
            n = 0;
            // Let a cell already on show go by, then catch its next fetch
            while (raddr === 14'h0005 && n < 20) begin
                @(negedge clk);
                n++;
            end
            while (raddr !== 14'h0005 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            repeat (13) @(negedge clk);
            g7 = codes[i][7] & ~inv_m[i];
            a9 = codes[i][6] & ~(g7 & alt_m[i]);
            blk = g7 & ~alt_m[i];
            e = {8'h00, g7, codes[i][5], a9, codes[i][4:0]};
            chk_v("glyph code", e, {8'h00, gaddr[11:4]});
            e = {12'h000, srow[3:0] + (blk ? 4'h0 : 4'hF)};
            chk_v("glyph row", e, {12'h000, gaddr[3:0]});
        end
        opreg.inverse = 1'b0;
        alt = 1'b0;
        $display("test glyph done");
    endtask : t_glyph
    // Writes and reads on both pages, bit 10 replaced by the page bit
    task automatic t_access;
        logic [10:0] ad [4] = '{11'h023, 11'h023, 11'h423, 11'h023};
        logic [7:0]  dv [4] = '{8'h5A, 8'hA5, 8'h5A, 8'hA5};
        logic [7:0]  q;
        logic [2:0]  seen;
        int          w, l;
        for (int i = 0; i < 4; i++) begin
            opreg.page = i[0];
            host.access(i < 2, ad[i], dv[i], q, w, l, seen);
            chk_n("stall cycles", 1, int'(w >= 1 && w <= 17));
            chk_v("phase oe off", (i < 2) ? 16'h0001 : 16'h0002, {13'h0000, seen});
            chk_n("strobe low cycles", (i < 2) ? 6 : 0, l);
            if (i >= 2) chk_v("read byte", {8'h00, dv[i]}, {8'h00, q});
            repeat (2) @(negedge clk);
            chk_v("oe after release", 16'h0000, {15'h0000, oe});
        end
        $display("test access done");
    endtask : t_access
    // Line length, sync width, visible width and row stepping
    task automatic t_raster;
        int         hi, on, vh, dh;
        logic       prev;
        logic [4:0] r0;
        wait_hs_rise();
        r0 = srow;
        hi = 0;
        on = 0;
        vh = 0;
        dh = 0;
        prev = 1'b0;
        for (int k = 0; k < 1600; k++) begin
            hi += int'(hs === 1'b1);
            on += int'(act === 1'b1);
            vh += int'(vs === 1'b1);
            dh += int'(dot === 1'b1);
            prev = hs;
            @(negedge clk);
        end
        chk_n("line length", 1, int'(hs === 1'b1 && prev === 1'b0));
        chk_n("sync width", 128, hi);
        chk_n("active width", 1024, on);
        chk_n("vsync in text rows", 0, vh);
        chk_n("dot clock high", 800, dh);
        chk_v("scan row step", {11'h000, (r0 == 5'h0B) ? 5'h00 : r0 + 5'h01}, {11'h000, srow});
        $display("test raster done");
    endtask : t_raster
    // Blanked dots, then hires dots under both dot clock phases
    task automatic t_blank;
        int ones [3];
        for (int h = 0; h < 3; h++) begin
            hires = (h > 0);
            dsel = (h == 2);
            wait_hs_rise();
            ones[h] = 0;
            repeat (128) begin
                @(negedge clk);
                ones[h] += int'(video === 1'b1);
            end
        end
        chk_n("blank dots", 0, ones[0]);
        chk_n("hires dots", 1, int'(ones[1] > 0 && ones[2] > 0));
        chk_n("dot phases", 128, ones[1] + ones[2]);
        $display("test blank done");
    endtask : t_blank
    // Clock enable low freezes the raster and the dot clock
    task automatic t_hold;
        logic [13:0] a0;
        logic        p0, d0;
        ce = 1'b0;
        @(negedge clk);
        a0 = raddr;
        p0 = phase;
        d0 = dot;
        repeat (5) @(negedge clk);
        chk_v("frozen state", {a0, p0, d0}, {raddr, phase, dot});
        ce = 1'b1;
        $display("test hold done");
    endtask : t_hold
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        bad_count = 0;
        total_checks = 0;
        rstn = 1'b0;
        opreg = '0;
        {alt, hires, dsel, start_wr} = 4'h0;
        ce = 1'b1;
        saddr = 14'h0000;
        glyph = 8'hFF;
        repeat (12) @(negedge clk);
        chk_v("reset outputs", 16'h003C, {10'h000, stall_n, strobe_n, buf_n, phase, video, oe});
        $display("test reset done");
        rstn = 1'b1;
        @(negedge clk);
        saddr = 14'h0123;
        start_wr = 1'b1;
        @(negedge clk);
        start_wr = 1'b0;
        t_glyph();
        t_access();
        t_raster();
        t_blank();
        t_hold();
        final_report();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        final_report();
    end
endmodule : tvd_core_tb
`default_nettype wire
